// ---- hw/remappable_pin_select_mux.sv ----
/*
 * Register-controlled remapping of package pins to peripheral inputs and
 * of peripheral output functions to remappable pins 0 to 7.
 * Assumes pad inputs and peripheral outputs synchronous to core_clk, and
 * an AXI4-Lite master that keeps valid and payload stable until ready.
 * SMALL_PACKAGE is set only for the smallest package variant, where the
 * output map field of one remappable pin is absent.
 */
`timescale 1ns/100ps

module remappable_pin_select_mux #(
    parameter int NUM_PINS      = 64,
    parameter int NUM_FUNCS     = 64,
    parameter bit SMALL_PACKAGE = 1'b0
) (
    // Clock and reset.
    input  wire logic                       core_clk,
    input  wire logic                       reset,
    // AXI4-Lite write address channel.
    input  wire logic [11:0]                s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    // AXI4-Lite write data channel.
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    // AXI4-Lite write response channel.
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    // AXI4-Lite read address channel.
    input  wire logic [11:0]                s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    // AXI4-Lite read data channel.
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    // Pad side.
    input  wire logic [NUM_PINS-1:0]        remappable_pin_in,
    output logic [7:0]                      remappable_bidir_pin_out,
    output logic [7:0]                      remappable_bidir_pin_oe,
    // Peripheral side.
    input  wire logic [NUM_FUNCS-1:0]       periph_out_func,
    output pin_mux_pkg::periph_in_s         periph_in
);

    // Selector storage; one six-bit field per routed input or pin.
    // Kept as arrays so the generate loops below index them directly.
    logic [5:0]  in_sel_r  [pin_mux_pkg::NUM_IN_SEL];
    logic [5:0]  out_sel_r [pin_mux_pkg::NUM_OUT_PINS];

    // Bus handshake state. Address and data beats are held apart
    // because the master may offer them in either order.
    logic        aw_held_r;
    logic        w_held_r;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [1:0]  rresp_r;
    logic [31:0] rdata_r;

    // Routed outputs, all registered so that pads and peripherals never
    // see the combinational select path.
    logic [pin_mux_pkg::NUM_IN_SEL-1:0]   route_in_r;
    logic [pin_mux_pkg::NUM_OUT_PINS-1:0] pin_out_r;
    logic [pin_mux_pkg::NUM_OUT_PINS-1:0] pin_oe_r;

    // Decode wires.
    logic        wr_fire;
    logic [3:0]  wr_idx;
    logic        wr_mapped;
    logic        wr_lo_en;
    logic        wr_hi_en;
    logic [5:0]  wr_lo_val;
    logic [5:0]  wr_hi_val;
    logic        ar_fire;
    logic [3:0]  rd_idx;
    logic        rd_mapped;
    logic [15:0] reg_view [pin_mux_pkg::NUM_REGS];
    logic [15:0] rd_word;

    // Each address and data channel is taken on its own; a held beat
    // blocks further beats until the response has been accepted.
    // Only one write and one read are under way at a time, which trades
    // throughput for a single set of held registers.
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready  = !w_held_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;

    // Write decode; the register write happens once both beats are held.
    // A misaligned or out-of-window address still completes, with an
    // error response, so a stray access cannot hang the master.
    assign wr_fire   = aw_held_r && w_held_r && !bvalid_r;
    assign wr_idx    = awaddr_r[5:2];
    assign wr_mapped = (awaddr_r[11:6] == 6'h00) &&
                       (awaddr_r[1:0] == 2'h0) &&
                       (wr_idx < 4'(pin_mux_pkg::NUM_REGS));
    assign wr_lo_en  = wr_fire && wr_mapped && wstrb_r[0];
    assign wr_hi_en  = wr_fire && wr_mapped && wstrb_r[1];
    assign wr_lo_val = wdata_r[pin_mux_pkg::LO_FIELD_LSB +: 6];
    assign wr_hi_val = wdata_r[pin_mux_pkg::HI_FIELD_LSB +: 6];

    // Read decode. The view array has fewer entries than the index can
    // name, so the mapped check must guard every lookup.
    assign ar_fire   = s_axi_arvalid && s_axi_arready;
    assign rd_idx    = s_axi_araddr[5:2];
    assign rd_mapped = (s_axi_araddr[11:6] == 6'h00) &&
                       (s_axi_araddr[1:0] == 2'h0) &&
                       (rd_idx < 4'(pin_mux_pkg::NUM_REGS));
    assign rd_word   = rd_mapped ? reg_view[rd_idx] : 16'h0000;

    // Input select register views; unimplemented bits are constant zero.
    // Writes to those bits are simply dropped by the field decode.
    assign reg_view[0] = {2'h0, in_sel_r[0], 2'h0, in_sel_r[1]};
    assign reg_view[1] = {10'h000, in_sel_r[2]};
    assign reg_view[2] = {2'h0, in_sel_r[3], 2'h0, in_sel_r[4]};
    assign reg_view[3] = {2'h0, in_sel_r[5], 2'h0, in_sel_r[6]};
    assign reg_view[4] = {10'h000, in_sel_r[7]};

    // Input selectors: each field listens to its own register and half.
    for (genvar i = 0; i < pin_mux_pkg::NUM_IN_SEL; i++) begin : g_in
        logic       hit;
        logic       lane_en;
        logic [5:0] lane_val;
        logic       pin_ok;
        logic       pin_bit;

        assign hit      = wr_idx == pin_mux_pkg::IN_REG_IDX[i];
        assign lane_en  = hit && (pin_mux_pkg::IN_IS_HI[i] ? wr_hi_en
                                                          : wr_lo_en);
        assign lane_val = pin_mux_pkg::IN_IS_HI[i] ? wr_hi_val : wr_lo_val;

        // Selectors start at all ones, so every peripheral sees pad 63, the last of the default 64 pads.
        // A field only changes when its own byte strobe is set.
        always_ff @(posedge core_clk) begin
            if (reset) begin
                in_sel_r[i] <= pin_mux_pkg::IN_SEL_RESET;
            end else if (lane_en) begin
                in_sel_r[i] <= lane_val;
            end
        end

        // Selections past the last pad read low instead of indexing out,
        // which keeps a reduced pad count from routing an unknown level.
        assign pin_ok  = int'(in_sel_r[i]) < NUM_PINS;
        assign pin_bit = pin_ok ? remappable_pin_in[in_sel_r[i]] : 1'b0;

        // One flop per routed input: the peripheral sees a new selection
        // one cycle after it is written, never a half-switched mux.
        always_ff @(posedge core_clk) begin
            if (reset) begin
                route_in_r[i] <= 1'b0;
            end else begin
                route_in_r[i] <= pin_bit;
            end
        end
    end

    // The struct msb is selector 0, so the vector maps in reverse.
    for (genvar i = 0; i < pin_mux_pkg::NUM_IN_SEL; i++) begin : g_pack
        assign periph_in[pin_mux_pkg::NUM_IN_SEL-1-i] = route_in_r[i];
    end

    // Output map registers: even pin in the low half, odd in the high.
    for (genvar p = 0; p < pin_mux_pkg::NUM_OUT_PINS; p++) begin : g_out
        localparam int REG_IDX = pin_mux_pkg::OUT_REG_BASE + p / 2;
        localparam bit ODD     = (p % 2) == 1;
        localparam bit ABSENT  = SMALL_PACKAGE &&
                                 (p == pin_mux_pkg::SMALL_PKG_ABSENT_PIN);
        logic lane_en;
        logic func_ok;
        logic func_bit;
        logic drive_en;

        assign lane_en = (wr_idx == 4'(REG_IDX)) &&
                         (ODD ? wr_hi_en : wr_lo_en);

        // An absent field never takes a write and so always reads zero.
        always_ff @(posedge core_clk) begin
            if (reset) begin
                out_sel_r[p] <= pin_mux_pkg::OUT_SEL_RESET;
            end else if (lane_en && !ABSENT) begin
                out_sel_r[p] <= ODD ? wr_hi_val : wr_lo_val;
            end
        end

        // Function 0 releases the pin; a code beyond the last function
        // also releases it rather than driving an unknown level.
        assign func_ok  = int'(out_sel_r[p]) < NUM_FUNCS;
        assign func_bit = func_ok ? periph_out_func[out_sel_r[p]] : 1'b0;
        assign drive_en = func_ok && (out_sel_r[p] != 6'h00);

        // Drive is registered so a change on another pin's selector
        // cannot glitch this one; the cost is one cycle of latency.
        always_ff @(posedge core_clk) begin
            if (reset) begin
                pin_out_r[p] <= 1'b0;
                pin_oe_r[p]  <= 1'b0;
            end else begin
                pin_out_r[p] <= func_bit;
                pin_oe_r[p]  <= drive_en;
            end
        end
    end

    // Output map register views built from pin pairs.
    for (genvar r = 0; r < pin_mux_pkg::NUM_OUT_PINS / 2; r++) begin : g_view
        assign reg_view[pin_mux_pkg::OUT_REG_BASE + r] =
            {2'h0, out_sel_r[2*r+1], 2'h0, out_sel_r[2*r]};
    end

    assign remappable_bidir_pin_out = pin_out_r;
    assign remappable_bidir_pin_oe  = pin_oe_r;

    // Write address and data capture; either may arrive first.
    // The held flag stops a second address from overwriting a beat that
    // is still waiting for its data.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            aw_held_r <= 1'b0;
            awaddr_r  <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_r <= 1'b0;
        end
    end

    // Write data capture.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            w_held_r <= 1'b0;
            wdata_r  <= 32'h0000_0000;
            wstrb_r  <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_r <= 1'b0;
        end
    end

    // Write response; unmapped addresses get an error and change nothing.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            bvalid_r <= 1'b0;
            bresp_r  <= pin_mux_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_mapped ? pin_mux_pkg::RESP_OKAY
                                  : pin_mux_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Read data; the upper half of the word always reads zero.
    // arready stays low while an answer waits, so read data never
    // changes under a pending rvalid.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rvalid_r <= 1'b0;
            rresp_r  <= pin_mux_pkg::RESP_OKAY;
            rdata_r  <= 32'h0000_0000;
        end else if (ar_fire) begin
            rvalid_r <= 1'b1;
            rresp_r  <= rd_mapped ? pin_mux_pkg::RESP_OKAY
                                  : pin_mux_pkg::RESP_SLVERR;
            rdata_r  <= {16'h0000, rd_word};
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

endmodule

// ---- hw/pin_mux_pkg.sv ----
/*
 * Constants, register map and carrier types for the remappable pin mux.
 * Assumes a 32-bit AXI4-Lite register bus with 16-bit registers held in
 * the low half of each aligned word.
 */
package pin_mux_pkg;

    // Width of every pin or function selector field.
    localparam int SEL_W = 6;

    // Byte offsets of the selection registers.
    localparam logic [11:0] SPI2_CLOCK_DATA_INPUT_SELECT   = 12'h000;
    localparam logic [11:0] SPI2_SLAVE_SELECT_INPUT_SELECT = 12'h004;
    localparam logic [11:0] UART4_INPUT_SELECT             = 12'h008;
    localparam logic [11:0] SPI3_CLOCK_DATA_INPUT_SELECT   = 12'h00c;
    localparam logic [11:0] SPI3_SLAVE_SELECT_INPUT_SELECT = 12'h010;
    localparam logic [11:0] PIN0_PIN1_OUTPUT_MAP           = 12'h014;
    localparam logic [11:0] PIN2_PIN3_OUTPUT_MAP           = 12'h018;
    localparam logic [11:0] PIN4_PIN5_OUTPUT_MAP           = 12'h01c;
    localparam logic [11:0] PIN6_PIN7_OUTPUT_MAP           = 12'h020;

    // Register count, index of the first output map register, and selector and pin counts.
    localparam int NUM_REGS     = 9;
    localparam int OUT_REG_BASE = 5;
    localparam int NUM_IN_SEL   = 8;
    localparam int NUM_OUT_PINS = 8;

    // Field positions inside a two-field register.
    localparam int HI_FIELD_LSB = 8;
    localparam int LO_FIELD_LSB = 0;

    // Reset values: input selectors all ones, output maps all zeros.
    localparam logic [5:0] IN_SEL_RESET  = 6'h3f;
    localparam logic [5:0] OUT_SEL_RESET = 6'h00;

    // Remappable pin whose output map is absent on the small package.
    localparam int SMALL_PKG_ABSENT_PIN = 5;

    // Register index and field half of each input selector, in the
    // order of the peripheral input struct below (1 means bits 13-8).
    localparam logic [3:0] IN_REG_IDX [NUM_IN_SEL] =
        '{4'h0, 4'h0, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3, 4'h4};
    localparam logic IN_IS_HI [NUM_IN_SEL] =
        '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

    // AXI4-Lite response codes.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Layout of a 16-bit selection register.
    typedef struct packed {
        logic [1:0] rsv_hi;
        logic [5:0] hi;
        logic [1:0] rsv_lo;
        logic [5:0] lo;
    } sel_reg_s;

    // Routed inputs toward the peripherals, msb is selector 0.
    typedef struct packed {
        logic spi2_clock_input;
        logic spi2_serial_data_input;
        logic spi2_slave_select_input;
        logic uart4_clear_to_send_input;
        logic uart4_receive_input;
        logic spi3_clock_input;
        logic spi3_serial_data_input;
        logic spi3_slave_select_input;
    } periph_in_s;

endpackage

// ---- sim/remappable_pin_select_mux_monitor.sv ----
/* Concurrent checks on the ports of the remappable pin mux.
   Assumes single-clock operation and a master that offers AW and W
   together, as the bench does. */
`timescale 1ns/100ps
module remappable_pin_select_mux_monitor #(
    parameter int NUM_PINS = 64
) (
    // Clock and reset.
    input wire logic                    core_clk,
    input wire logic                    reset,
    // Register bus.
    input wire logic                    s_axi_awvalid,
    input wire logic                    s_axi_awready,
    input wire logic                    s_axi_wvalid,
    input wire logic                    s_axi_wready,
    input wire logic                    s_axi_bvalid,
    input wire logic [11:0]             s_axi_araddr,
    input wire logic                    s_axi_arvalid,
    input wire logic                    s_axi_arready,
    input wire logic [31:0]             s_axi_rdata,
    input wire logic [1:0]              s_axi_rresp,
    input wire logic                    s_axi_rvalid,
    // Pads and peripherals.
    input wire logic [NUM_PINS-1:0]     remappable_pin_in,
    input wire logic [7:0]              remappable_bidir_pin_oe,
    input wire pin_mux_pkg::periph_in_s periph_in
);
    // Stays set until the first write is taken, so reset maps still hold.
    logic fresh_r;
    always_ff @(posedge core_clk) begin
        if (reset) fresh_r <= 1'b1;
        else if (s_axi_awvalid && s_axi_awready) fresh_r <= 1'b0;
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_ar_take; s_axi_arvalid && s_axi_arready; endsequence
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    // The first edge after reset still shows the reset image, so skip it.
    property p_reset_route;
        fresh_r && !$past(reset) |->
            periph_in == {8{$past(remappable_pin_in[NUM_PINS-1])}};
    endproperty
    a_reset_route: assert property (p_reset_route)
        else $error("routed input differs from last pin at reset");
    property p_reset_oe; fresh_r |-> remappable_bidir_pin_oe == 8'h00;
    endproperty
    a_reset_oe: assert property (p_reset_oe)
        else $error("pin driven before any output map write");
    property p_wr_resp; s_wr_take |-> ##[1:2] s_axi_bvalid; endproperty
    a_wr_resp: assert property (p_wr_resp)
        else $error("write response late");
    property p_rd_resp; s_ar_take |=> s_axi_rvalid; endproperty
    a_rd_resp: assert property (p_rd_resp)
        else $error("read data late");
    property p_rsv_zero;
        s_axi_rvalid |-> s_axi_rdata[31:14] == 18'h0 && !s_axi_rdata[7:6];
    endproperty
    a_rsv_zero: assert property (p_rsv_zero)
        else $error("unimplemented bits read nonzero");
    property p_ss_zero;
        s_ar_take ##0 (s_axi_araddr == 12'h004 || s_axi_araddr == 12'h010)
            |=> s_axi_rvalid && s_axi_rdata[15:6] == 10'h0;
    endproperty
    a_ss_zero: assert property (p_ss_zero)
        else $error("slave select register upper bits nonzero");
    property p_bad_rd;
        s_ar_take ##0 (s_axi_araddr >= 12'h024)
            |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
    endproperty
    a_bad_rd: assert property (p_bad_rd)
        else $error("unmapped read not refused");
    property p_r_hold; s_axi_rvalid |=> $stable(s_axi_rdata) || !s_axi_rvalid;
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data changed while pending");
endmodule

bind remappable_pin_select_mux remappable_pin_select_mux_monitor
    #(.NUM_PINS(NUM_PINS)) i_mon (.core_clk, .reset, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .remappable_pin_in,
    .remappable_bidir_pin_oe, .periph_in);

// ---- sim/remappable_pin_select_mux_test.sv ----
/* Self-checking bench for the remappable pin mux.
   Assumes the package, the mux and its monitor are compiled first. */
`timescale 1ns/100ps
module remappable_pin_select_mux_test;
    logic                    core_clk, reset;
    logic [11:0]             s_axi_awaddr, s_axi_araddr;
    logic [31:0]             s_axi_wdata, s_axi_rdata, q, d;
    logic [3:0]              s_axi_wstrb, s;
    logic [1:0]              s_axi_bresp, s_axi_rresp, r;
    logic                    s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic                    s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic                    s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic                    s_axi_rready;
    logic [63:0]             remappable_pin_in, periph_out_func;
    logic [7:0]              remappable_bidir_pin_out, remappable_bidir_pin_oe;
    pin_mux_pkg::periph_in_s periph_in;
    logic [15:0]             m [9];
    logic [15:0]             fm;
    logic [31:0]             sm_rdata;
    logic [7:0]              sm_oe;
    int                      err_total, n_tests, seed, a;
    // Register and field half of each routed input, msb first.
    int                      ri [8] = '{0, 0, 1, 2, 2, 3, 3, 4};
    bit                      hf [8] = '{1, 0, 0, 1, 0, 1, 0, 0};

    remappable_pin_select_mux i_dut (.core_clk, .reset, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .remappable_pin_in, .remappable_bidir_pin_out,
        .remappable_bidir_pin_oe, .periph_out_func, .periph_in);

    // Smallest-package twin on the same inputs; only its read data and
    // pin enables are compared, to show the absent pin 5 map.
    remappable_pin_select_mux #(.SMALL_PACKAGE(1'b1)) i_small (.core_clk,
        .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(),
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(),
        .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(sm_rdata),
        .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready,
        .remappable_pin_in, .remappable_bidir_pin_out(),
        .remappable_bidir_pin_oe(sm_oe), .periph_out_func, .periph_in());

    // Free-running 20 MHz clock.
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Implemented bits of a register; slave selects have one field.
    function automatic logic [15:0] msk(int i);
        return (i == 1 || i == 4) ? 16'h003f : 16'h3f3f;
    endfunction

    // Expected routed inputs from the modelled selectors.
    function automatic logic [7:0] ein();
        for (int k = 0; k < 8; k++) begin
            ein[7-k] = remappable_pin_in[hf[k] ? m[ri[k]][13:8]
                                                 : m[ri[k]][5:0]];
        end
    endfunction

    // Expected enables in the upper byte and pin data in the lower byte.
    function automatic logic [15:0] eout();
        logic [5:0] f;
        for (int p = 0; p < 8; p++) begin
            f = p[0] ? m[5 + p/2][13:8] : m[5 + p/2][5:0];
            eout[p] = periph_out_func[f];
            eout[8+p] = f != 6'h00;
        end
    endfunction

    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // One bus transfer; a hung slave is cut off after twenty cycles.
    task automatic bus(input bit w, input logic [11:0] ad,
                       input logic [31:0] dt, input logic [3:0] st);
        int n;
        @(posedge core_clk);
        s_axi_awaddr <= ad;
        s_axi_araddr <= ad;
        s_axi_wdata <= dt;
        s_axi_wstrb <= st;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        for (n = 0; n < 20; n++) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (w ? s_axi_bvalid : s_axi_rvalid) break;
        end
        r = w ? s_axi_bresp : s_axi_rresp;
        q = s_axi_rdata;
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        if (n == 20) begin
            err_total++;
            wrap_up();
        end
    endtask

    // Reset, reset contents, refusals, then random selections.
    initial begin
        seed = 32'hb0f8;
        reset = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        remappable_pin_in = {$random(seed), $random(seed)};
        periph_out_func = {$random(seed), $random(seed)};
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            m[i] = i < 5 ? msk(i) : 16'h0000;
            bus(0, 12'(i * 4), 32'h0, 4'h0);
            chk("reset value", q, {16'h0, m[i]});
        end
        chk("reset route", periph_in, ein());
        chk("reset pins", {remappable_bidir_pin_oe,
            remappable_bidir_pin_out}, eout());
        bus(0, 12'h024, 32'h0, 4'h0);
        chk("unmapped read", {r, q[29:0]}, 32'h80000000);
        bus(1, 12'h028, 32'hffffffff, 4'hf);
        chk("unmapped write", r, 2'h2);
        for (int t = 0; t < 60; t++) begin
            a = t < 9 ? t : $unsigned($random(seed)) % 9;
            d = t < 9 ? 32'hffffffff : $random(seed);
            s = t < 9 ? 4'hf : $random(seed);
            bus(1, 12'(a * 4), d, s);
            chk("write resp", r, 2'h0);
            fm = msk(a) & {{8{s[1]}}, {8{s[0]}}};
            m[a] = (m[a] & ~fm) | (d[15:0] & fm);
            bus(0, 12'(a * 4), 32'h0, 4'h0);
            chk("read back", q, {16'h0, m[a]});
            chk("read resp", r, 2'h0);
            chk("small read", sm_rdata,
                {16'h0, a == 7 ? m[a] & 16'h003f : m[a]});
            remappable_pin_in <= {$random(seed), $random(seed)};
            periph_out_func <= {$random(seed), $random(seed)};
            repeat (2) @(posedge core_clk);
            chk("input route", periph_in, ein());
            chk("output route", {remappable_bidir_pin_oe,
                remappable_bidir_pin_out}, eout());
            chk("small enables", sm_oe, eout() >> 8 & 16'h00df);
        end
        wrap_up();
    end
endmodule
